// *** pkg/pleq_pkg.sv ***
package pleq_pkg;

  localparam int LIST_DEPTH    = 512;   // entries in the list
  localparam int NUM_VOUT      = 64;    // internal output bits
  localparam int NUM_TIMERS    = 32;    // delay timers
  localparam int NUM_SHOTS     = 32;    // one-shot state bits
  localparam int NUM_LATCHES   = 32;    // memory latches
  localparam int NUM_OPERANDS  = 256;   // state flags offered
  localparam int STACK_DEPTH   = 32;    // result stack bits
  localparam logic [4:0] GATE_MIN = 5'h02;
  localparam logic [4:0] GATE_MAX = 5'h10;
  localparam logic [9:0] LAST_ENTRY = 10'h1ff;
  localparam logic [9:0] LIST_END   = 10'h200;

  // timing: timer settings count milliseconds
  localparam int CLK_PERIOD_NS = 100;
  localparam int TIMER_UNIT_NS = 1000000;
  localparam int TICK_CYCLES   = TIMER_UNIT_NS / CLK_PERIOD_NS;

  // opcode of a list entry
  typedef enum logic [3:0] {
    OP_END       = 4'h0,
    OP_OPERAND   = 4'h1,
    OP_VOUT      = 4'h2,
    OP_OR        = 4'h3,
    OP_AND       = 4'h4,
    OP_NOR       = 4'h5,
    OP_NAND      = 4'h6,
    OP_NOT       = 4'h7,
    OP_XOR       = 4'h8,
    OP_LATCH     = 4'h9,
    OP_POS_SHOT  = 4'ha,
    OP_NEG_SHOT  = 4'hb,
    OP_DUAL_SHOT = 4'hc,
    OP_TIMER     = 4'hd,
    OP_ASSIGN    = 4'he
  } pleq_op_type;

  // one list entry: opcode and its index or input count
  typedef struct packed {
    pleq_op_type op;
    logic [7:0]  arg;
  } pleq_entry_type;

  localparam pleq_entry_type END_ENTRY = '{op: OP_END, arg: 8'h00};

  // editor command kinds
  localparam logic [1:0] CMD_WRITE  = 2'h0;
  localparam logic [1:0] CMD_INSERT = 2'h1;
  localparam logic [1:0] CMD_DELETE = 2'h2;

  typedef struct packed {
    logic           valid;
    logic [1:0]     kind;
    logic [8:0]     index;
    pleq_entry_type entry;
  } pleq_cmd_type;

  // per-timer delays in milliseconds
  typedef struct packed {
    logic [15:0] pickup;
    logic [15:0] dropout;
  } pleq_timer_cfg_type;

  typedef enum logic [6:0] {
    S_INIT  = 7'h01,
    S_CHECK = 7'h02,
    S_IDLE  = 7'h04,
    S_FETCH = 7'h08,
    S_EXEC  = 7'h10,
    S_SHRD  = 7'h20,
    S_SHWR  = 7'h40
  } pleq_state_type;

endpackage

// *** rtl/pleq_engine.sv ***
`timescale 1ns/1ns
module pleq_engine #(
  parameter int TICK_CYCLES = pleq_pkg::TICK_CYCLES
) (
  input  wire logic                         ref_clk,
  input  wire logic                         reset_n,
  input  wire pleq_pkg::pleq_cmd_type       cmd,
  input  wire logic [255:0]                 operands,
  input  wire pleq_pkg::pleq_timer_cfg_type [31:0] timerCfg,
  output logic                              cmdReady_q,
  output logic [63:0]                       internalOutputBit_q,
  output logic                              syntaxErr_q,
  output logic                              stackErr_q,
  output logic                              passDone_q
);

  //////////////////////////////////////////////////////////////////////////////
  // reset release

  logic [1:0] rstSync_q;  // release pipeline for reset_n
  logic       rstN;       // clean copy used by every other process

  // reset asserts at once but leaves only on a clock edge
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      rstSync_q <= 2'h0;
    end else begin
      rstSync_q <= {rstSync_q[0], 1'b1};
    end
  end

  assign rstN = rstSync_q[1];

  //////////////////////////////////////////////////////////////////////////////
  // declarations

  pleq_pkg::pleq_state_type state_q;      // sequencer state
  pleq_pkg::pleq_state_type state_d;      // next sequencer state
  logic [8:0]               addr_q;       // fill, scan or shift pointer
  logic [8:0]               addr_d;       // next pointer
  logic                     checking_q;   // scan is a recompile check
  logic                     checkStart;   // a recompile begins now
  logic [1:0]               kind_q;       // edit being carried out
  logic [8:0]               index_q;      // entry the edit aims at
  pleq_pkg::pleq_entry_type newEntry_q;   // entry an insert puts in
  logic                     wrEn;         // store write strobe
  logic [8:0]               wrAddr;       // store write address
  pleq_pkg::pleq_entry_type wrData;       // store write data
  logic [8:0]               rdAddr;       // store read address
  pleq_pkg::pleq_entry_type rdData;       // entry read last cycle
  logic                     lastAddr;     // pointer on the last entry
  logic                     isEnd;        // entry read is a terminator
  logic                     exec;         // an entry is evaluated now
  logic [4:0]               slotIdx;      // latch, one-shot or timer
  logic [5:0]               voutIdx;      // internal output selected
  logic [31:0]              stack_q;      // result stack, top in bit 0
  logic [5:0]               sp_q;         // results on the stack
  logic [31:0]              popped;       // stack with inputs removed
  logic [31:0]              popMask;      // inputs a gate takes
  logic [5:0]               gateCnt;      // gate input count
  logic                     gateBad;      // gate count out of range
  logic [5:0]               needCnt;      // results an operator takes
  logic                     badArg;       // operator argument illegal
  logic                     result;       // value pushed back
  logic                     stackFault;   // under- or overflow
  logic [31:0]              latch_q;      // memory latches
  logic [31:0]              shotPrev_q;   // one-shot input, last pass
  logic [31:0]              usedTimer_q;  // timers met by the check
  logic [63:0]              usedVout_q;   // assignments met by check
  logic [31:0]              tickCnt_q;    // cycles into the millisecond
  logic                     msTick_q;     // one cycle per millisecond
  wire  [31:0]              timerOut;     // settled timer outputs
  wire  [31:0]              timerRes;     // value a timer pushes now

  //////////////////////////////////////////////////////////////////////////////
  // entry store

  pleq_list_mem pleq_list_mem_i (
    .clk      (ref_clk),
    .wrEn     (wrEn),
    .wrAddr   (wrAddr),
    .wrData   (wrData),
    .rdAddr   (rdAddr),
    .rdData_q (rdData)
  );

  assign lastAddr = (addr_q == pleq_pkg::LAST_ENTRY[8:0]);
  assign isEnd    = (rdData.op == pleq_pkg::OP_END);
  assign exec     = (state_q == pleq_pkg::S_EXEC) && !isEnd;
  assign slotIdx  = rdData.arg[4:0];
  assign voutIdx  = rdData.arg[5:0];

  //////////////////////////////////////////////////////////////////////////////
  // sequencer: fill, edit, recompile check and evaluation passes

  // next state, store access and recompile start
  always_comb begin
    state_d    = state_q;
    addr_d     = addr_q;
    checkStart = 1'b0;
    wrEn       = 1'b0;
    wrAddr     = addr_q;
    wrData     = pleq_pkg::END_ENTRY;
    rdAddr     = addr_q;
    case (state_q)
      pleq_pkg::S_INIT: begin
        // every entry starts as a terminator
        wrEn   = 1'b1;
        addr_d = addr_q + 9'h001;
        if (lastAddr) begin
          state_d    = pleq_pkg::S_FETCH;
          checkStart = 1'b1;
        end
      end
      pleq_pkg::S_IDLE: begin
        // edits win over the next pass; passes run back to back
        addr_d  = 9'h000;
        state_d = pleq_pkg::S_FETCH;
        if (cmd.valid) begin
          case (cmd.kind)
            pleq_pkg::CMD_INSERT: begin
              addr_d  = pleq_pkg::LAST_ENTRY[8:0];
              state_d = pleq_pkg::S_SHRD;
            end
            pleq_pkg::CMD_DELETE: begin
              addr_d  = cmd.index;
              state_d = pleq_pkg::S_SHRD;
            end
            default: begin
              // overwrite; an unknown kind only recompiles
              wrEn       = (cmd.kind == pleq_pkg::CMD_WRITE);
              wrAddr     = cmd.index;
              wrData     = cmd.entry;
              checkStart = 1'b1;
            end
          endcase
        end
      end
      pleq_pkg::S_FETCH: begin
        state_d = checking_q ? pleq_pkg::S_CHECK : pleq_pkg::S_EXEC;
      end
      pleq_pkg::S_CHECK, pleq_pkg::S_EXEC: begin
        if (isEnd || lastAddr) begin
          state_d = pleq_pkg::S_IDLE;
        end else begin
          addr_d  = addr_q + 9'h001;
          state_d = pleq_pkg::S_FETCH;
        end
      end
      pleq_pkg::S_SHRD: begin
        if (kind_q == pleq_pkg::CMD_INSERT) begin
          if (addr_q == index_q) begin
            // gap opened, the new entry goes
            wrEn       = 1'b1;
            wrData     = newEntry_q;
            addr_d     = 9'h000;
            state_d    = pleq_pkg::S_FETCH;
            checkStart = 1'b1;
          end else begin
            rdAddr  = addr_q - 9'h001;
            state_d = pleq_pkg::S_SHWR;
          end
        end else begin
          if (lastAddr) begin
            // delete refills the tail with a terminator
            wrEn       = 1'b1;
            addr_d     = 9'h000;
            state_d    = pleq_pkg::S_FETCH;
            checkStart = 1'b1;
          end else begin
            rdAddr  = addr_q + 9'h001;
            state_d = pleq_pkg::S_SHWR;
          end
        end
      end
      pleq_pkg::S_SHWR: begin
        // an insert loses whatever stood in the last entry
        wrEn    = 1'b1;
        wrData  = rdData;
        state_d = pleq_pkg::S_SHRD;
        if (kind_q == pleq_pkg::CMD_INSERT) begin
          addr_d = addr_q - 9'h001;
        end else begin
          addr_d = addr_q + 9'h001;
        end
      end
      default: begin
        state_d = pleq_pkg::S_INIT;
      end
    endcase
  end

  // state and pointer
  always_ff @(posedge ref_clk or negedge rstN) begin
    if (!rstN) begin
      state_q <= pleq_pkg::S_INIT;
      addr_q  <= 9'h000;
    end else begin
      state_q <= state_d;
      addr_q  <= addr_d;
    end
  end

  // scan kind: check after the fill or an edit, evaluate otherwise
  always_ff @(posedge ref_clk or negedge rstN) begin
    if (!rstN) begin
      checking_q <= 1'b0;
    end else if (checkStart) begin
      checking_q <= 1'b1;
    end else if (state_q == pleq_pkg::S_IDLE) begin
      checking_q <= 1'b0;
    end
  end

  // edit capture; taken only while ready stands
  always_ff @(posedge ref_clk or negedge rstN) begin
    if (!rstN) begin
      kind_q     <= pleq_pkg::CMD_WRITE;
      index_q    <= 9'h000;
      newEntry_q <= pleq_pkg::END_ENTRY;
    end else if ((state_q == pleq_pkg::S_IDLE) && cmd.valid) begin
      kind_q     <= cmd.kind;
      index_q    <= cmd.index;
      newEntry_q <= cmd.entry;
    end
  end

  // handshake and pass strobes
  always_ff @(posedge ref_clk or negedge rstN) begin
    if (!rstN) begin
      cmdReady_q <= 1'b0;
      passDone_q <= 1'b0;
    end else begin
      cmdReady_q <= (state_d == pleq_pkg::S_IDLE);
      passDone_q <= (state_q == pleq_pkg::S_EXEC) && (isEnd || lastAddr);
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // operator evaluation

  assign popMask = (32'h1 << rdData.arg[4:0]) - 32'h1;
  assign popped  = stack_q >> needCnt;
  assign gateCnt = {1'b0, rdData.arg[4:0]};
  assign gateBad = (rdData.arg < {3'h0, pleq_pkg::GATE_MIN}) ||
                   (rdData.arg > {3'h0, pleq_pkg::GATE_MAX});

  // result and input count of the entry read
  always_comb begin
    needCnt = 6'h00;
    badArg  = 1'b0;
    result  = 1'b0;
    case (rdData.op)
      pleq_pkg::OP_OPERAND: begin
        result = operands[rdData.arg];
      end
      pleq_pkg::OP_VOUT: begin
        // not yet assigned this pass: last pass value
        result = internalOutputBit_q[voutIdx];
      end
      pleq_pkg::OP_OR: begin
        needCnt = gateCnt;
        badArg  = gateBad;
        result  = |(stack_q & popMask);
      end
      pleq_pkg::OP_AND: begin
        needCnt = gateCnt;
        badArg  = gateBad;
        result  = &(stack_q | ~popMask);
      end
      pleq_pkg::OP_NOR: begin
        needCnt = gateCnt;
        badArg  = gateBad;
        result  = ~|(stack_q & popMask);
      end
      pleq_pkg::OP_NAND: begin
        needCnt = gateCnt;
        badArg  = gateBad;
        result  = ~&(stack_q | ~popMask);
      end
      pleq_pkg::OP_NOT: begin
        needCnt = 6'h01;
        result  = ~stack_q[0];
      end
      pleq_pkg::OP_XOR: begin
        needCnt = 6'h02;
        result  = stack_q[0] ^ stack_q[1];
      end
      pleq_pkg::OP_LATCH: begin
        // reset on top, set beneath; reset dominates
        needCnt = 6'h02;
        result  = ~stack_q[0] & (stack_q[1] | latch_q[slotIdx]);
      end
      pleq_pkg::OP_POS_SHOT: begin
        needCnt = 6'h01;
        result  = stack_q[0] & ~shotPrev_q[slotIdx];
      end
      pleq_pkg::OP_NEG_SHOT: begin
        needCnt = 6'h01;
        result  = ~stack_q[0] & shotPrev_q[slotIdx];
      end
      pleq_pkg::OP_DUAL_SHOT: begin
        needCnt = 6'h01;
        result  = stack_q[0] ^ shotPrev_q[slotIdx];
      end
      pleq_pkg::OP_TIMER: begin
        needCnt = 6'h01;
        result  = timerRes[slotIdx];
      end
      pleq_pkg::OP_ASSIGN: begin
        needCnt = 6'h01;
        result  = stack_q[0];
      end
      default: begin
        badArg = (rdData.op != pleq_pkg::OP_END);
      end
    endcase
  end

  // stack misuse: missing inputs, overflow, leftovers at assignment
  always_comb begin
    stackFault = badArg || (sp_q < needCnt);
    if ((needCnt == 6'h00) && (sp_q == 6'h20)) begin
      stackFault = 1'b1;
    end
    if ((rdData.op == pleq_pkg::OP_ASSIGN) && (sp_q != 6'h01)) begin
      stackFault = 1'b1;
    end
  end

  // stack: pop the inputs, push the single result
  always_ff @(posedge ref_clk or negedge rstN) begin
    if (!rstN) begin
      stack_q <= 32'h0;
      sp_q    <= 6'h00;
    end else if (state_q == pleq_pkg::S_IDLE) begin
      stack_q <= 32'h0;
      sp_q    <= 6'h00;
    end else if (exec) begin
      if (stackFault || (rdData.op == pleq_pkg::OP_ASSIGN)) begin
        // assignment closes the equation, a fault drops it
        stack_q <= 32'h0;
        sp_q    <= 6'h00;
      end else begin
        stack_q <= {popped[30:0], result};
        sp_q    <= sp_q - needCnt + 6'h01;
      end
    end
  end

  // stack fault flag; a new fault beats the recompile clear
  always_ff @(posedge ref_clk or negedge rstN) begin
    if (!rstN) begin
      stackErr_q <= 1'b0;
    end else if (exec && stackFault) begin
      stackErr_q <= 1'b1;
    end else if (checkStart) begin
      stackErr_q <= 1'b0;
    end
  end

  // internal outputs, written in place so later reads see them
  always_ff @(posedge ref_clk or negedge rstN) begin
    if (!rstN) begin
      internalOutputBit_q <= 64'h0;
    end else if (exec && !stackFault &&
                 (rdData.op == pleq_pkg::OP_ASSIGN)) begin
      internalOutputBit_q[voutIdx] <= result;
    end
  end

  // latches: lost at power-up and on recompile
  always_ff @(posedge ref_clk or negedge rstN) begin
    if (!rstN) begin
      latch_q <= 32'h0;
    end else if (checkStart) begin
      latch_q <= 32'h0;
    end else if (exec && !stackFault &&
                 (rdData.op == pleq_pkg::OP_LATCH)) begin
      latch_q[slotIdx] <= result;
    end
  end

  // one-shot history, one bit per shot slot
  always_ff @(posedge ref_clk or negedge rstN) begin
    if (!rstN) begin
      shotPrev_q <= 32'h0;
    end else if (exec && !stackFault &&
                 ((rdData.op == pleq_pkg::OP_POS_SHOT) ||
                  (rdData.op == pleq_pkg::OP_NEG_SHOT) ||
                  (rdData.op == pleq_pkg::OP_DUAL_SHOT))) begin
      shotPrev_q[slotIdx] <= stack_q[0];
    end
  end

  // recompile check: a timer or an assignment used twice
  always_ff @(posedge ref_clk or negedge rstN) begin
    if (!rstN) begin
      usedTimer_q <= 32'h0;
      usedVout_q  <= 64'h0;
      syntaxErr_q <= 1'b0;
    end else if (checkStart) begin
      usedTimer_q <= 32'h0;
      usedVout_q  <= 64'h0;
      syntaxErr_q <= 1'b0;
    end else if ((state_q == pleq_pkg::S_CHECK) && !isEnd) begin
      if (rdData.op == pleq_pkg::OP_TIMER) begin
        if (usedTimer_q[slotIdx]) begin
          syntaxErr_q <= 1'b1;
        end
        usedTimer_q[slotIdx] <= 1'b1;
      end
      if (rdData.op == pleq_pkg::OP_ASSIGN) begin
        if (usedVout_q[voutIdx]) begin
          syntaxErr_q <= 1'b1;
        end
        usedVout_q[voutIdx] <= 1'b1;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // delay timers

  // millisecond time base shared by every timer
  always_ff @(posedge ref_clk or negedge rstN) begin
    if (!rstN) begin
      tickCnt_q <= 32'h0;
      msTick_q  <= 1'b0;
    end else if (tickCnt_q == 32'(TICK_CYCLES - 1)) begin
      tickCnt_q <= 32'h0;
      msTick_q  <= 1'b1;
    end else begin
      tickCnt_q <= tickCnt_q + 32'h1;
      msTick_q  <= 1'b0;
    end
  end

  // one timer per slot; a zero delay follows within the pass
  for (genvar t = 0; t < pleq_pkg::NUM_TIMERS; t++) begin : g_timer
    logic        in_q;       // start input seen on the last pass
    logic        out_q;      // settled timer output
    logic [15:0] elapsed_q;  // milliseconds since the input moved
    logic [15:0] delay;      // delay toward the pending level
    logic        hit;        // this timer evaluated now

    assign delay       = in_q ? timerCfg[t].pickup : timerCfg[t].dropout;
    assign hit         = exec && !stackFault &&
                         (rdData.op == pleq_pkg::OP_TIMER) &&
                         (slotIdx == 5'(t));
    assign timerOut[t] = out_q;
    assign timerRes[t] = (stack_q[0] ? (timerCfg[t].pickup == 16'h0) :
                         (timerCfg[t].dropout == 16'h0)) ? stack_q[0] : out_q;

    // timing runs on the millisecond tick, so resolution is one millisecond
    always_ff @(posedge ref_clk or negedge rstN) begin
      if (!rstN) begin
        in_q      <= 1'b0;
        out_q     <= 1'b0;
        elapsed_q <= 16'h0;
      end else if (hit) begin
        in_q  <= stack_q[0];
        out_q <= timerRes[t];
        if (stack_q[0] != in_q) begin
          elapsed_q <= 16'h0;
        end
      end else if (msTick_q && (in_q != out_q)) begin
        if ((elapsed_q + 16'h1) >= delay) begin
          out_q     <= in_q;
          elapsed_q <= 16'h0;
        end else begin
          elapsed_q <= elapsed_q + 16'h1;
        end
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // assertions

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rstN);

  sequence s_pass_step;
    exec && !lastAddr;
  endsequence

  sequence s_latch_reset;
    exec && !stackFault && (rdData.op == pleq_pkg::OP_LATCH) && stack_q[0];
  endsequence

  sequence s_pos_edge;
    exec && !stackFault && (rdData.op == pleq_pkg::OP_POS_SHOT) &&
      stack_q[0] && !shotPrev_q[slotIdx];
  endsequence

  a_pass_order: assert property (s_pass_step |=> (state_q ==
    pleq_pkg::S_FETCH) && (addr_q == $past(addr_q) + 9'h001))
    else $error("entries not taken in order");
  a_end_stops: assert property ((state_q == pleq_pkg::S_EXEC) && isEnd
    |=> (state_q == pleq_pkg::S_IDLE) && passDone_q)
    else $error("terminator did not end the pass");
  a_latch_reset: assert property (s_latch_reset |=>
    !latch_q[$past(slotIdx)])
    else $error("latch not reset dominant");
  a_latch_clear: assert property (checkStart |=> (latch_q == 32'h0))
    else $error("latches kept over recompile");
  a_assign_copy: assert property (exec && !stackFault &&
    (rdData.op == pleq_pkg::OP_ASSIGN) |=>
    (internalOutputBit_q[$past(voutIdx)] == $past(stack_q[0])))
    else $error("output not copied from top");
  a_init_fill: assert property ((state_q == pleq_pkg::S_INIT) |->
    wrEn && (wrData == pleq_pkg::END_ENTRY))
    else $error("fill wrote other than a terminator");
  a_shot_rise: assert property (s_pos_edge |=> stack_q[0])
    else $error("rising one-shot did not fire");
endmodule

// *** rtl/pleq_list_mem.sv ***
`timescale 1ns/1ns
// entry store, registered read data
module pleq_list_mem (
  input  wire logic                     clk,
  input  wire logic                     wrEn,
  input  wire logic [8:0]               wrAddr,
  input  wire pleq_pkg::pleq_entry_type wrData,
  input  wire logic [8:0]               rdAddr,
  output pleq_pkg::pleq_entry_type      rdData_q
);
  pleq_pkg::pleq_entry_type mem [0:pleq_pkg::LIST_DEPTH-1];

  // write port
  always_ff @(posedge clk) begin
    if (wrEn) begin
      mem[wrAddr] <= wrData;
    end
  end

  // read port, one cycle latency
  always_ff @(posedge clk) begin
    rdData_q <= mem[rdAddr];
  end
endmodule

// *** sim/pleq_flags.sv ***
`timescale 1ns/1ns
// state flags and timer settings
module pleq_flags (
  input  wire logic                           ref_clk,
  input  wire logic                           clr,
  input  wire logic [7:0]                     sel,
  input  wire logic                           val,
  output logic [255:0]                        flags,
  output pleq_pkg::pleq_timer_cfg_type [31:0] cfg
);
  // zero delays: timers pass straight through
  assign cfg = '0;
  // one flag changes per edge
  always_ff @(posedge ref_clk) begin
    if (clr) flags <= '0;
    else flags[sel] <= val;
  end
endmodule

// *** sim/test_pleq_engine.sv ***
`timescale 1ns/1ns
module test_pleq_engine;
  logic clk = 0, rstN = 0, clr = 1, val = 0, rdy, done, synErr, stkErr;
  int shotSeen = 0;
  logic [7:0] sel = 0;
  logic [255:0] flags;
  logic [63:0] vout;
  pleq_pkg::pleq_cmd_type cmd = '0;
  pleq_pkg::pleq_timer_cfg_type [31:0] cfg;
  int fail_count = 0, comparisons = 0, cyc = 0;
  initial forever #50 clk = ~clk;
  pleq_flags pleq_flags_i (.ref_clk(clk), .clr(clr), .sel(sel),
    .val(val), .flags(flags), .cfg(cfg));
  pleq_engine pleq_engine_i (.ref_clk(clk), .reset_n(rstN), .cmd(cmd),
    .operands(flags), .timerCfg(cfg), .cmdReady_q(rdy),
    .internalOutputBit_q(vout), .syntaxErr_q(synErr), .stackErr_q(stkErr),
    .passDone_q(done));
  task automatic give_verdict;
    $display("fails %0d of %0d", fail_count, comparisons);
    if (fail_count == 0 && comparisons > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  task automatic cmp(input logic v, input logic e);
    comparisons++;
    if (v !== e) begin
      fail_count++;
      $display("CHECK FAILED t=%0t got %h exp %h", $time, v, e);
    end
  endtask
  // hold the command until ready is seen at an edge
  task automatic put(input logic [1:0] k, input logic [8:0] i,
    input pleq_pkg::pleq_op_type op, input logic [7:0] a);
    @(posedge clk) #1 cmd = '{1'b1, k, i, '{op, a}};
    do @(posedge clk); while (rdy !== 1'b1);
    #1 cmd.valid = 1'b0;
  endtask
  task automatic setf(input logic [7:0] s, input logic v);
    @(posedge clk) #1 sel = s;
    val = v;
  endtask
  // two pass ends, so one whole pass sees the new state
  task automatic pass;
    repeat (2) @(posedge done);
    #1;
  endtask
  // flags 0 and 1 into a two-input and, then to output 0
  task automatic and_gate;
    put(pleq_pkg::CMD_WRITE, 9'h000, pleq_pkg::OP_OPERAND, 8'h00);
    put(pleq_pkg::CMD_WRITE, 9'h001, pleq_pkg::OP_OPERAND, 8'h01);
    put(pleq_pkg::CMD_WRITE, 9'h002, pleq_pkg::OP_AND, 8'h02);
    put(pleq_pkg::CMD_WRITE, 9'h003, pleq_pkg::OP_ASSIGN, 8'h00);
    setf(8'h00, 1'b1);
    setf(8'h01, 1'b1);
    pass;
    cmp(vout[0], 1'b1);
    setf(8'h01, 1'b0);
    pass;
    cmp(vout[0], 1'b0);
  endtask
  // inverter inserted ahead of the and, rest shift down
  task automatic insert_not;
    put(pleq_pkg::CMD_INSERT, 9'h002, pleq_pkg::OP_NOT, 8'h00);
    pass;
    cmp(vout[0], 1'b1);
  endtask
  // set 2, reset 3 into latch 0, then to output 1
  task automatic latch_seal;
    put(pleq_pkg::CMD_WRITE, 9'h005, pleq_pkg::OP_OPERAND, 8'h02);
    put(pleq_pkg::CMD_WRITE, 9'h006, pleq_pkg::OP_OPERAND, 8'h03);
    put(pleq_pkg::CMD_WRITE, 9'h007, pleq_pkg::OP_LATCH, 8'h00);
    put(pleq_pkg::CMD_WRITE, 9'h008, pleq_pkg::OP_ASSIGN, 8'h01);
    setf(8'h02, 1'b1);
    pass;
    cmp(vout[1], 1'b1);
    setf(8'h02, 1'b0);
    pass;
    cmp(vout[1], 1'b1);
    setf(8'h02, 1'b1);
    setf(8'h03, 1'b1);
    pass;
    cmp(vout[1], 1'b0);
    setf(8'h03, 1'b0);
    pass;
    setf(8'h02, 1'b0);
    pass;
    cmp(vout[1], 1'b1);
    put(pleq_pkg::CMD_WRITE, 9'h008, pleq_pkg::OP_ASSIGN, 8'h01);
    pass;
    cmp(vout[1], 1'b0);
  endtask
  // output 0 shared through a rising one-shot into output 2
  always @(posedge done) shotSeen = shotSeen + vout[2];
  task automatic one_shot;
    put(pleq_pkg::CMD_WRITE, 9'h009, pleq_pkg::OP_VOUT, 8'h00);
    put(pleq_pkg::CMD_WRITE, 9'h00a, pleq_pkg::OP_POS_SHOT, 8'h00);
    put(pleq_pkg::CMD_WRITE, 9'h00b, pleq_pkg::OP_ASSIGN, 8'h02);
    setf(8'h01, 1'b1);
    pass;
    shotSeen = 0;
    setf(8'h01, 1'b0);
    pass;
    cmp(shotSeen == 1, 1'b1);
    setf(8'h01, 1'b1);
    pass;
    cmp(shotSeen == 1, 1'b1);
    cmp(vout[2], 1'b0);
  endtask
  // stack misuse, terminator masking and duplicate assignment
  task automatic errors;
    put(pleq_pkg::CMD_WRITE, 9'h00d, pleq_pkg::OP_NOT, 8'h00);
    pass;
    cmp(stkErr, 1'b0);
    put(pleq_pkg::CMD_WRITE, 9'h00c, pleq_pkg::OP_NOT, 8'h00);
    pass;
    cmp(stkErr, 1'b1);
    put(pleq_pkg::CMD_WRITE, 9'h00d, pleq_pkg::OP_ASSIGN, 8'h00);
    put(pleq_pkg::CMD_WRITE, 9'h00c, pleq_pkg::OP_OPERAND, 8'h00);
    pass;
    cmp(synErr, 1'b1);
    put(pleq_pkg::CMD_WRITE, 9'h00c, pleq_pkg::OP_END, 8'h00);
    pass;
    cmp(synErr, 1'b0);
    cmp(stkErr, 1'b0);
  endtask
  // removing the inverter shifts the and back up
  task automatic delete_not;
    put(pleq_pkg::CMD_DELETE, 9'h002, pleq_pkg::OP_END, 8'h00);
    pass;
    cmp(vout[0], 1'b1);
  endtask
  // hang guard
  always @(posedge clk) if (++cyc == 20000) begin
    fail_count++;
    give_verdict;
  end
  initial begin
    repeat (6) @(posedge clk);
    #1 rstN = 1;
    clr = 0;
    and_gate;
    insert_not;
    latch_seal;
    one_shot;
    errors;
    delete_not;
    give_verdict;
  end
endmodule
